/* hw/dsl_serial_load.sv */
// dac serial load interface: shift register, bit counter and dac update latch
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - sample serial data on each of a frame's first eight serial clock falling edges into 8-bit register.
// - frame select low enables clock, data and shift register.
// - after frame select falls, next eight falling edges carry one bit each.
// - dac output updates from input register when load strobe falls.
// - load strobe held low updates dac after eight edges with frame low.
module dsl_serial_load (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       serial_clk,
  input  wire logic       serial_data_in,
  input  wire logic       frame_sel_n,
  input  wire logic       dac_load_strobe_n,
  output logic [7:0]      dac_code,
  output logic [7:0]      input_word,
  output logic            dac_update
);
  // reset release through two flops
  logic [1:0] rst_sync;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_sync <= 2'b00;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end
  wire logic rst_q_n = rst_sync[1];

  // input pipeline: every pin passes s1, s2 and s3 on clk_sys; s1 is only a
  // metastability catcher and feeds nothing but s2. a level counts once s2
  // and s3 agree, so a pin must stay put for at least two clk_sys cycles.
  // serial data is taken from s3 together with the clock edge decision, so
  // both see the pins at the same moment; the host keeps data steady around
  // its falling edge, which covers the skew between the two pins
  // three-stage samplers; stage 1 feeds stage 2 only, change counts when 2 and 3 agree
  dsl_pkg::dsl_link_t s1, s2, s3;
  always_ff @(posedge clk_sys or negedge rst_q_n) begin
    if (!rst_q_n) begin
      s1 <= 4'hf;
      s2 <= 4'hf;
      s3 <= 4'hf;
    end else begin
      s1 <= '{serial_clk, serial_data_in, frame_sel_n, dac_load_strobe_n};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // warm-up: the stages leave reset preset high, so a pin that idles low would
  // look like a falling edge straight after reset; edges stay masked until
  // every stage and the filter hold the real pin level
  logic [2:0] warm_cnt;
  wire logic  primed = (warm_cnt == dsl_pkg::WARM_CYCLES);
  always_ff @(posedge clk_sys or negedge rst_q_n) begin
    if (!rst_q_n)     warm_cnt <= 3'h0;
    else if (!primed) warm_cnt <= warm_cnt + 3'h1;
  end

  // per-signal filtered level: copies stage 3 while warming up, then only
  // moves when stages 2 and 3 agree, so a lone odd sample never counts
  dsl_pkg::dsl_link_t filt;
  always_ff @(posedge clk_sys or negedge rst_q_n) begin
    if (!rst_q_n)     filt <= 4'hf;
    else if (!primed) filt <= s3;
    else              filt <= ~(s2 ^ s3) & s3 | (s2 ^ s3) & filt;
  end

  // edge decode; sclk falls far slower than clk_sys (160 ns bench period).
  // the cost of the filter is a detection lag of three to four clk_sys
  // cycles, which limits the serial clock to well below the pin rating
  wire logic sclk_fall = primed & filt.sclk & ~s3.sclk & ~s2.sclk;
  wire logic load_fall = primed & filt.load_n & ~s3.load_n & ~s2.load_n;
  wire logic frame_low = ~filt.frame_n;
  // data sampled from stage 3 with its clock edge, same pipeline depth
  wire logic data_bit  = s3.sdata;

  dsl_pkg::dsl_state_t state, next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] next_input_word;
  logic [7:0] next_dac_code;

  // auto mode is strobe low but not its falling edge this cycle, so a strobe
  // that falls together with the eighth edge loads the word without that edge's bit;
  // edges past the eighth find the shifter in the full state and are dropped
  wire logic shift_ok  = frame_low & sclk_fall & (state == dsl_pkg::DSL_SHIFT);
  wire logic last_bit  = shift_ok & (bit_cnt == dsl_pkg::FRAME_BITS - 4'h1);
  wire logic auto_mode = ~filt.load_n & ~load_fall;
  wire logic auto_upd  = auto_mode & last_bit;
  wire logic strobe_upd = load_fall;

  // frame sequencing
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_input_word = input_word;
    unique case (state)
      dsl_pkg::DSL_IDLE: begin
        if (frame_low) begin
          next_state   = dsl_pkg::DSL_SHIFT;
          next_bit_cnt = dsl_pkg::CNT_RST;
        end
      end
      dsl_pkg::DSL_SHIFT: begin
        if (!frame_low) begin
          next_state = dsl_pkg::DSL_IDLE;
        end else if (shift_ok) begin
          next_input_word = {input_word[6:0], data_bit};
          next_bit_cnt    = bit_cnt + 4'h1;
          if (last_bit) next_state = dsl_pkg::DSL_FULL;
        end
      end
      dsl_pkg::DSL_FULL: begin
        // further edges in the frame are ignored until frame select rises
        if (!frame_low) next_state = dsl_pkg::DSL_IDLE;
      end
      default: next_state = dsl_pkg::DSL_IDLE;
    endcase
  end

  // dac latch: strobe edge or auto mode completion
  always_comb begin
    next_dac_code = dac_code;
    if (auto_upd)        next_dac_code = next_input_word;
    else if (strobe_upd) next_dac_code = input_word;
  end

  always_ff @(posedge clk_sys or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state      <= dsl_pkg::DSL_IDLE;
      bit_cnt    <= dsl_pkg::CNT_RST;
      input_word <= dsl_pkg::INPUT_RST;
      dac_code   <= dsl_pkg::DAC_RST;
      dac_update <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      input_word <= next_input_word;
      dac_code   <= next_dac_code;
      dac_update <= auto_upd | strobe_upd;
    end
  end

  // checks
  a_shift_hold: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    !frame_low |=> input_word == $past(input_word))
    else $error("input word changed with frame select high");
  a_shift_step: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    shift_ok |=> input_word == {$past(input_word[6:0]), $past(data_bit)})
    else $error("shift did not take serial bit");
  a_strobe_load: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (strobe_upd && !auto_upd) |=> dac_code == $past(input_word) && dac_update)
    else $error("dac not loaded on strobe fall");
  a_auto_load: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    auto_upd |=> dac_code == input_word)
    else $error("auto update missed");
  a_frame_len: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_FULL) |-> bit_cnt == dsl_pkg::FRAME_BITS)
    else $error("frame closed at wrong count");
  a_frame_open: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_IDLE && frame_low) |=> state == dsl_pkg::DSL_SHIFT && bit_cnt == 4'h0)
    else $error("frame select low did not arm shifter");
  a_dac_quiet: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    !(strobe_upd || auto_upd) |=> dac_code == $past(dac_code) && !dac_update)
    else $error("dac changed without update");
  a_full_hold: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_FULL) |=> input_word == $past(input_word))
    else $error("extra edge shifted after frame");

  // multi-step checks are built from these sequences; they watch the
  // decoded edges, so they say nothing about pin timing itself
  sequence s_last_edge;
    shift_ok && last_bit;
  endsequence
  sequence s_word_closed;
    state == dsl_pkg::DSL_FULL && bit_cnt == dsl_pkg::FRAME_BITS;
  endsequence
  sequence s_auto_loaded;
    dac_update && dac_code == input_word;
  endsequence

  // the eighth accepted edge closes the frame with a full count
  a_frame_close: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    s_last_edge |=> s_word_closed)
    else $error("eighth edge did not close the frame");
  // in auto mode the eighth edge also drives the new word to the dac
  a_auto_eighth: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    s_last_edge ##0 auto_mode |=> s_auto_loaded)
    else $error("auto mode did not load after eighth edge");
  // a frame dropped before its eighth edge never triggers an auto update
  a_short_quiet: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_SHIFT && !frame_low && !strobe_upd) |=> !dac_update)
    else $error("auto update from a short frame");
  // the bit counter never runs past one frame
  a_cnt_bound: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    bit_cnt <= dsl_pkg::FRAME_BITS)
    else $error("bit counter beyond frame length");
  // a full frame keeps its count until frame select rises
  a_full_count: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_FULL) |=> bit_cnt == $past(bit_cnt))
    else $error("bit count moved after the frame closed");
  // no dac update and no shift while the samplers are still filling after reset
  a_warm_quiet: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    !primed |=> !dac_update && input_word == $past(input_word))
    else $error("output moved during sampler warm-up");
  // one strobe fall gives one load, never a run of them
  a_strobe_once: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    strobe_upd |=> !strobe_upd)
    else $error("strobe fall decoded twice");
  // an idle shifter keeps its word whatever the serial pins do
  a_idle_hold: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state == dsl_pkg::DSL_IDLE) |=> input_word == $past(input_word))
    else $error("input word changed while idle");
  // frame select going high always returns the shifter to idle
  a_desel_idle: assert property (@(posedge clk_sys) disable iff (!rst_q_n)
    (state != dsl_pkg::DSL_IDLE && !frame_low) |=> state == dsl_pkg::DSL_IDLE)
    else $error("shifter stayed armed after frame select rose");
endmodule
`default_nettype wire

/* inc/dsl_pkg.sv */
// package for the dac serial load interface: constants and carrier types
package dsl_pkg;
  localparam int          DATA_W       = 8;        // bits per frame and dac code width
  localparam int          CNT_W        = 4;        // bit counter width
  localparam logic [3:0]  FRAME_BITS   = 4'h8;     // falling edges per frame
  localparam logic [7:0]  INPUT_RST    = 8'h00;    // input register after reset
  localparam logic [7:0]  DAC_RST      = 8'h00;    // dac code after reset
  localparam logic [3:0]  CNT_RST      = 4'h0;     // bit counter after reset
  localparam logic [2:0]  WARM_CYCLES  = 3'h4;     // clk_sys edges before pin edges count
  localparam int          SYS_PERIOD_NS = 8;       // clk_sys period
  localparam int          SCLK_MAX_MHZ  = 50;      // host serial clock ceiling
  // link pins after sampling
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic frame_n;
    logic load_n;
  } dsl_link_t;
  // frame progress
  typedef enum logic [1:0] {
    DSL_IDLE  = 2'b00,
    DSL_SHIFT = 2'b01,
    DSL_FULL  = 2'b10
  } dsl_state_t;
endpackage

/* tb/dsl_host_model.sv */
// host model: drives frames onto the serial load pins
`timescale 1ns/100ps
`default_nettype none
module dsl_host_model (
  input  wire logic clk_sys,
  output logic      serial_clk = 1'b1,
  output logic      serial_data_in = 1'b0,
  output logic      frame_sel_n = 1'b1
);
  // 160 ns link clock, msb first, still between frames; sel low leaves the device deselected
  task automatic send(input logic [7:0] w, input int n, input logic sel);
    @(posedge clk_sys) #1 frame_sel_n = !sel;
    for (int i = 0; i < n; i++) begin
      serial_data_in = (i < 8) ? w[7-i] : ~serial_data_in;
      #80 serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
    end
    #80 frame_sel_n = 1'b1;
    serial_data_in = ~serial_data_in; // a released line must not keep its value
  endtask
endmodule
`default_nettype wire

/* tb/dsl_serial_load_tb.sv */
// self-checking bench for the dac serial load interface
`timescale 1ns/100ps
`default_nettype none
module dsl_serial_load_tb;
  logic        clk_sys = 1'b0, rst_n = 1'b0, dac_load_strobe_n = 1'b0;
  logic        serial_clk, serial_data_in, frame_sel_n, dac_update, au;
  logic [7:0]  dac_code, input_word, op, pulses = 8'h00;
  logic [7:0]  ex = dsl_pkg::INPUT_RST, dc = dsl_pkg::DAC_RST;
  int          err_count = 0, checks_done = 0, seed = 32'hdfde876d;
  // 125 MHz clock; count dac update pulses
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (dac_update === 1'b1) pulses <= pulses + 8'h01;
  dsl_host_model dsl_host_model_i (.clk_sys, .serial_clk, .serial_data_in, .frame_sel_n);
  dsl_serial_load dsl_serial_load_i (.clk_sys, .rst_n, .serial_clk, .serial_data_in,
    .frame_sel_n, .dac_load_strobe_n, .dac_code, .input_word, .dac_update);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) $display("ERROR %s expected %h seen %h", nm, exp, got);
    err_count += int'(got !== exp);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic frame(input logic [7:0] v, input int n, input logic sel);
    op = pulses;
    dsl_host_model_i.send(v, n, sel);
    for (int i = 0; i < n && i < 8 && sel; i++) ex = {ex[6:0], v[7-i]};
    au = sel && n >= 8 && dac_load_strobe_n === 1'b0;
    dc = au ? ex : dc;
    check("word", input_word, ex);
    check("code", dac_code, dc);
    check("updates", pulses - op, {7'h00, au});
    $display("test frame %h of %0d bits done", v, n);
  endtask
  initial begin // watchdog, far beyond a dozen frames of about 200 cycles
    repeat (10000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
  // auto mode (edge value, deselected, short, overlong), then strobe mode
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check("code", dac_code, dc);
    repeat (8) @(posedge clk_sys);
    #1;
    for (int t = 0; t < 12; t++) begin
      seed = xs(seed);
      dac_load_strobe_n = (t >= 8);
      frame(t == 0 ? 8'hff : seed[7:0], t == 6 ? 5 : 8 + (t == 7), t != 5);
      if (dac_load_strobe_n === 1'b1) dc = ex;
      op = pulses;
      @(posedge clk_sys) #1 dac_load_strobe_n = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 check("code", dac_code, dc);
      check("strobe updates", pulses - op, {7'h00, t >= 8});
    end
    summarize();
  end
endmodule
`default_nettype wire
